//--- src/lin_status_pkg.sv
// Shared constants and helpers for the status readout link
// What this block does
// - Full status clears latched fault flags afterwards
// - Full status answers twice on diagnostic ID
// - Master may skip second full status header
// - Master prepares with short or diagnostic frame
// - Short preparation followed by header-only read
// - Short preparing ID bit5 clear, cmd, address
// - Top two ID bits are parity bits
// - First full response carries settings and flags
// - Position query leaves latched flags unchanged
// - Position signed 16-bit, unused LSBs zero
package lin_status_pkg;
  localparam logic [7:0] PID_DIAG_REQ = 8'h3C;
  localparam logic [7:0] PID_DIAG_RESP = 8'h7D;
  localparam logic [7:0] APP_REQUEST_CODE = 8'h80;
  localparam logic [6:0] CMD_POSITION = 7'h00;
  localparam logic [6:0] CMD_FULL_STATUS = 7'h01;
  localparam int FLAG_BIT = 7;
  localparam int ID_LEN_HI = 5;
  localparam logic [1:0] ID_LEN_FOUR = 2'h2;
  localparam logic [3:0] LEN_HEADER = 4'h0;
  localparam logic [3:0] LEN_SHORT = 4'h2;
  localparam logic [3:0] LEN_FOUR = 4'h4;
  localparam logic [3:0] LEN_DIAG = 4'h8;
  localparam logic [7:0] FILL_BYTE = 8'hFF;
  localparam logic [3:0] ONES_NIBBLE = 4'hF;
  localparam logic [15:0] POS_ALL = 16'hFFFF;
  // Latched flag positions
  localparam int FL_THERMAL_WARNING = 0;
  localparam int FL_THERMAL_SHUTDOWN = 1;
  localparam int FL_UNDERVOLTAGE = 2;
  localparam int FL_COIL_DEFECT = 3;
  localparam int FL_MISSED_STEP = 4;
  localparam int FL_CHARGE_PUMP = 5;
  localparam int FL_OVERCURRENT_X = 6;
  localparam int FL_OVERCURRENT_Y = 7;
  localparam int FL_SUPPLY_RESET = 8;
  localparam int FL_STALL = 9;
  localparam int FL_ABS_TRIP = 10;
  localparam int FL_DELTA_LOW = 11;
  localparam int FL_DELTA_HIGH = 12;
  localparam int NUM_FLAGS = 13;
  // Power-on raises supply reset
  localparam logic [12:0] FLAGS_RESET = 13'h0100;
  localparam logic [12:0] FLAGS_ALL = 13'h1FFF;
  // Controller register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_RESP0 = 8'h0C;
  localparam logic [7:0] REG_RESP1 = 8'h10;
  localparam logic [7:0] REG_RESP2 = 8'h14;
  localparam logic [7:0] REG_RESP3 = 8'h18;
  localparam logic [7:0] REG_IRQ_STAT = 8'h1C;
  localparam logic [7:0] REG_IRQ_EN = 8'h20;
  localparam logic [7:0] REG_IRQ_CLR = 8'h24;
  localparam int CTRL_GO = 0;
  localparam int CTRL_SECOND = 3;
  localparam int CFG_POS_ID = 8;
  localparam int CFG_PREP_ID = 16;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_NO_RESP = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    OP_POS_DIRECT = 2'h0,
    OP_POS_SHORT = 2'h1,
    OP_FULL_SHORT = 2'h2,
    OP_FULL_DIAG = 2'h3
  } op_e;

  // Byte k (1..8) of a frame; byte 1 sits in the top bits
  function automatic logic [7:0] dataByte(input logic [63:0] d,
                                          input logic [3:0] k);
    return d[8 * (8 - k) +: 8];
  endfunction : dataByte
endpackage : lin_status_pkg

//--- src/lin_frame_if.sv
// Frame-level link between bus master and positioner node
`timescale 1ns/1ps
interface lin_frame_if;
  logic hdrStb;
  logic [7:0] pid;
  logic [3:0] masterLen;
  logic [63:0] masterData;
  logic respStb;
  logic respValid;
  logic [3:0] respLen;
  logic [63:0] respData;

  modport master (
    output hdrStb,
    output pid,
    output masterLen,
    output masterData,
    input respStb,
    input respValid,
    input respLen,
    input respData
  );
  modport slave (
    input hdrStb,
    input pid,
    input masterLen,
    input masterData,
    output respStb,
    output respValid,
    output respLen,
    output respData
  );
endinterface : lin_frame_if

//--- src/lin_pid_parity.sv
// Protected identifier from a six-bit frame identifier
`timescale 1ns/1ps
module lin_pid_parity (
  input wire logic [5:0] id,
  output logic [7:0] pid
);
  always_comb begin
    pid = {~(id[1] ^ id[3] ^ id[4] ^ id[5]),
           id[0] ^ id[1] ^ id[2] ^ id[4], id};
  end
endmodule : lin_pid_parity

//--- src/lin_status_slave.sv
// Positioner end: decodes status requests and builds responses
`timescale 1ns/1ps
module lin_status_slave (
  input wire logic clk,
  input wire logic rst_n,
  lin_frame_if.slave lin,
  input wire logic [6:0] nodeAddr,
  input wire logic [5:0] posId,
  input wire logic [5:0] prepId,
  input wire logic endSwitchState,
  input wire logic [15:0] currentStepCount,
  input wire logic [1:0] microstepResolution,
  input wire logic [3:0] runCurrent,
  input wire logic [3:0] holdCurrent,
  input wire logic [3:0] speedMax,
  input wire logic [3:0] speedMin,
  input wire logic rampProfile,
  input wire logic shaftDir,
  input wire logic [3:0] accel,
  input wire logic [1:0] tempInfo,
  input wire logic [2:0] motionState,
  input wire logic [3:0] busErrors,
  input wire logic [3:0] absoluteThreshold,
  input wire logic [3:0] deltaThreshold,
  input wire logic [15:0] targetPos,
  input wire logic [10:0] secondPos,
  input wire logic [8:0] stallConfig,
  input wire logic [12:0] faultSet,
  output logic [12:0] latchedFlags
);
  typedef enum logic [1:0] {
    PEND_NONE = 2'h0,
    PEND_FULL1 = 2'h1,
    PEND_FULL2 = 2'h3,
    PEND_POS = 2'h2
  } pend_e;

  pend_e pending;
  logic [7:0] expPid;
  logic pidOk;
  logic [7:0] byte1;
  logic [7:0] byte2;
  logic [7:0] byte3;
  logic [7:0] cmdByte;
  logic [7:0] addrByte;
  logic shortPrep;
  logic diagPrep;
  logic prepHit;
  logic diagRead;
  logic directRead;
  logic [15:0] shownPos;
  logic [7:0] statusByte;
  logic [7:0] headByte;
  logic [63:0] posFrame;
  logic [63:0] fullFrame1;
  logic [63:0] fullFrame2;
  logic [12:0] clearMask;

  lin_pid_parity u_parity (
    .id(lin.pid[5:0]),
    .pid(expPid)
  );

  // Low bits void at coarse steps
  function automatic logic [15:0] maskPos(input logic [15:0] pos,
                                          input logic [1:0] mode);
    logic [15:0] keep;
    keep = lin_status_pkg::POS_ALL << mode;
    return pos & keep;
  endfunction : maskPos

  always_comb begin
    pidOk = (expPid == lin.pid);
    byte1 = lin_status_pkg::dataByte(lin.masterData, 4'h1);
    byte2 = lin_status_pkg::dataByte(lin.masterData, 4'h2);
    byte3 = lin_status_pkg::dataByte(lin.masterData, 4'h3);
  end

  always_comb begin
    shortPrep = lin.hdrStb && pidOk
      && lin.masterLen == lin_status_pkg::LEN_SHORT
      && !lin.pid[lin_status_pkg::ID_LEN_HI]
      && lin.pid[5:0] == prepId;
    diagPrep = lin.hdrStb && lin.pid == lin_status_pkg::PID_DIAG_REQ
      && lin.masterLen == lin_status_pkg::LEN_DIAG
      && byte1 == lin_status_pkg::APP_REQUEST_CODE;
    cmdByte = shortPrep ? byte1 : byte2;
    addrByte = shortPrep ? byte2 : byte3;
    // Both bytes carry a set flag bit
    prepHit = (shortPrep || diagPrep)
      && cmdByte[lin_status_pkg::FLAG_BIT]
      && addrByte[lin_status_pkg::FLAG_BIT]
      && addrByte[6:0] == nodeAddr;
    diagRead = lin.hdrStb && lin.pid == lin_status_pkg::PID_DIAG_RESP
      && lin.masterLen == lin_status_pkg::LEN_HEADER;
    directRead = lin.hdrStb && pidOk
      && lin.masterLen == lin_status_pkg::LEN_HEADER
      && lin.pid[5:0] == posId
      && lin.pid[5:4] == lin_status_pkg::ID_LEN_FOUR;
  end

  always_comb begin
    shownPos = maskPos(currentStepCount, microstepResolution);
    headByte = {endSwitchState, nodeAddr};
    statusByte = {latchedFlags[lin_status_pkg::FL_SUPPLY_RESET],
                  latchedFlags[lin_status_pkg::FL_MISSED_STEP],
                  latchedFlags[lin_status_pkg::FL_COIL_DEFECT],
                  latchedFlags[lin_status_pkg::FL_UNDERVOLTAGE],
                  latchedFlags[lin_status_pkg::FL_THERMAL_SHUTDOWN],
                  latchedFlags[lin_status_pkg::FL_THERMAL_WARNING],
                  tempInfo};
    posFrame = {headByte, shownPos, statusByte,
                lin_status_pkg::FILL_BYTE, lin_status_pkg::FILL_BYTE,
                lin_status_pkg::FILL_BYTE,
                lin_status_pkg::FILL_BYTE};
    fullFrame1 = {1'b1, nodeAddr,
                  runCurrent, holdCurrent,
                  speedMax, speedMin,
                  rampProfile, microstepResolution, shaftDir, accel,
                  statusByte,
                  motionState, endSwitchState,
                  latchedFlags[lin_status_pkg::FL_OVERCURRENT_X],
                  latchedFlags[lin_status_pkg::FL_OVERCURRENT_Y],
                  latchedFlags[lin_status_pkg::FL_STALL],
                  latchedFlags[lin_status_pkg::FL_CHARGE_PUMP],
                  lin_status_pkg::ONES_NIBBLE, busErrors,
                  absoluteThreshold, deltaThreshold};
    fullFrame2 = {1'b1, nodeAddr, shownPos, targetPos,
                  secondPos[7:0],
                  stallConfig[8:6], 1'b1, stallConfig[5],
                  secondPos[10:8],
                  latchedFlags[lin_status_pkg::FL_ABS_TRIP],
                  latchedFlags[lin_status_pkg::FL_DELTA_LOW],
                  latchedFlags[lin_status_pkg::FL_DELTA_HIGH],
                  stallConfig[4:0]};
  end

  // Answer owed to the latest preparation
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pending <= PEND_NONE;
    end else if (prepHit) begin
      // A new preparation overrides an unfetched second answer
      if (cmdByte[6:0] == lin_status_pkg::CMD_POSITION) begin
        pending <= PEND_POS;
      end else if (cmdByte[6:0] == lin_status_pkg::CMD_FULL_STATUS) begin
        pending <= PEND_FULL1;
      end else begin
        pending <= PEND_NONE;
      end
    end else if (diagRead) begin
      case (pending)
        PEND_FULL1: begin
          pending <= PEND_FULL2;
        end
        default: begin
          pending <= PEND_NONE;
        end
      endcase
    end
  end

  // Silence shows as no valid
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lin.respStb <= 1'b0;
      lin.respValid <= 1'b0;
      lin.respLen <= lin_status_pkg::LEN_HEADER;
      lin.respData <= '0;
    end else begin
      lin.respStb <= lin.hdrStb;
      lin.respValid <= 1'b0;
      lin.respLen <= lin_status_pkg::LEN_HEADER;
      lin.respData <= '0;
      if (directRead) begin
        lin.respValid <= 1'b1;
        lin.respLen <= lin_status_pkg::LEN_FOUR;
        lin.respData <= posFrame;
      end else if (diagRead && pending != PEND_NONE) begin
        lin.respValid <= 1'b1;
        lin.respLen <= lin_status_pkg::LEN_DIAG;
        case (pending)
          PEND_POS: begin
            lin.respData <= posFrame;
          end
          PEND_FULL1: begin
            lin.respData <= fullFrame1;
          end
          default: begin
            lin.respData <= fullFrame2;
          end
        endcase
      end
    end
  end

  // Clear once the first full answer goes
  always_comb begin
    clearMask = '0;
    if (diagRead && pending == PEND_FULL1) begin
      clearMask = lin_status_pkg::FLAGS_ALL;
    end
  end

  // Set wins over clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latchedFlags <= lin_status_pkg::FLAGS_RESET;
    end else begin
      latchedFlags <= (latchedFlags & ~clearMask) | faultSet;
    end
  end
endmodule : lin_status_slave

//--- src/lin_status_master.sv
// Bus master end: AXI4-Lite controlled status request sequencer
//
// Added by the designer: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module lin_status_master (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic irq,
  lin_frame_if.master lin
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_PREP = 3'h1,
    ST_PWAIT = 3'h3,
    ST_READ = 3'h2,
    ST_RWAIT = 3'h6,
    ST_READ2 = 3'h7,
    ST_R2WAIT = 3'h5
  } state_e;

  state_e state;
  lin_status_pkg::op_e op;
  logic fetchSecond;
  logic [31:0] cfg;
  logic [31:0] resp [4];
  logic [1:0] irqStat;
  logic [1:0] irqEn;
  logic [1:0] irqSet;
  logic [1:0] irqClr;
  logic [7:0] wAddr;
  logic [31:0] wVal;
  logic [3:0] wMask;
  logic awHave;
  logic wHave;
  logic doWrite;
  logic go;
  logic [5:0] idSel;
  logic [7:0] pidSel;
  logic [7:0] cmdField;
  logic [7:0] addrField;

  lin_pid_parity u_parity (
    .id(idSel),
    .pid(pidSel)
  );

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] val,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8 * i +: 8] = val[8 * i +: 8];
      end
    end
    return r;
  endfunction : merge

  always_comb begin
    doWrite = awHave && wHave && !bvalid;
    go = doWrite && wAddr == lin_status_pkg::REG_CTRL
      && wVal[lin_status_pkg::CTRL_GO] && state == ST_IDLE;
    irqClr = (doWrite && wAddr == lin_status_pkg::REG_IRQ_CLR)
      ? wVal[1:0] : 2'h0;
    // Short preparation: bit 5 clear
    idSel = (state == ST_PREP)
      ? {1'b0, cfg[lin_status_pkg::CFG_PREP_ID +: 5]}
      : cfg[lin_status_pkg::CFG_POS_ID +: 6];
    cmdField = {1'b1, (op == lin_status_pkg::OP_POS_SHORT)
      ? lin_status_pkg::CMD_POSITION : lin_status_pkg::CMD_FULL_STATUS};
    addrField = {1'b1, cfg[6:0]};
  end

  // Channels taken in either order
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awready <= 1'b0;
      wready <= 1'b0;
      awHave <= 1'b0;
      wHave <= 1'b0;
      wAddr <= '0;
      wVal <= '0;
      wMask <= '0;
      bvalid <= 1'b0;
      bresp <= lin_status_pkg::RESP_OKAY;
    end else begin
      awready <= awvalid && !awHave && !awready;
      wready <= wvalid && !wHave && !wready;
      if (awvalid && awready) begin
        awHave <= 1'b1;
        wAddr <= awaddr;
      end
      if (wvalid && wready) begin
        wHave <= 1'b1;
        wVal <= wdata;
        wMask <= wstrb;
      end
      if (doWrite) begin
        awHave <= 1'b0;
        wHave <= 1'b0;
        bvalid <= 1'b1;
        if (wAddr == lin_status_pkg::REG_CTRL
            || wAddr == lin_status_pkg::REG_CFG
            || wAddr == lin_status_pkg::REG_IRQ_EN
            || wAddr == lin_status_pkg::REG_IRQ_CLR) begin
          bresp <= lin_status_pkg::RESP_OKAY;
        end else begin
          bresp <= lin_status_pkg::RESP_SLVERR;
        end
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= '0;
      irqEn <= '0;
    end else if (doWrite && wAddr == lin_status_pkg::REG_CFG) begin
      cfg <= merge(cfg, wVal, wMask);
    end else if (doWrite && wAddr == lin_status_pkg::REG_IRQ_EN) begin
      irqEn <= 2'(merge({30'h0, irqEn}, wVal, wMask));
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= lin_status_pkg::RESP_OKAY;
    end else begin
      arready <= 1'b0;
      if (arvalid && !arready && !rvalid) begin
        arready <= 1'b1;
        rvalid <= 1'b1;
        rresp <= lin_status_pkg::RESP_OKAY;
        if (araddr == lin_status_pkg::REG_CTRL) begin
          rdata <= {28'h0, fetchSecond, op, 1'b0};
        end else if (araddr == lin_status_pkg::REG_CFG) begin
          rdata <= cfg;
        end else if (araddr == lin_status_pkg::REG_STAT) begin
          rdata <= {31'h0, state != ST_IDLE};
        end else if (araddr == lin_status_pkg::REG_RESP0) begin
          rdata <= resp[0];
        end else if (araddr == lin_status_pkg::REG_RESP1) begin
          rdata <= resp[1];
        end else if (araddr == lin_status_pkg::REG_RESP2) begin
          rdata <= resp[2];
        end else if (araddr == lin_status_pkg::REG_RESP3) begin
          rdata <= resp[3];
        end else if (araddr == lin_status_pkg::REG_IRQ_STAT) begin
          rdata <= {30'h0, irqStat};
        end else if (araddr == lin_status_pkg::REG_IRQ_EN) begin
          rdata <= {30'h0, irqEn};
        end else begin
          rdata <= '0;
          rresp <= lin_status_pkg::RESP_SLVERR;
        end
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // Sequencer; a go while busy is dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      op <= lin_status_pkg::OP_POS_DIRECT;
      fetchSecond <= 1'b0;
      lin.hdrStb <= 1'b0;
      lin.pid <= '0;
      lin.masterLen <= lin_status_pkg::LEN_HEADER;
      lin.masterData <= '0;
      irqSet <= '0;
      for (int i = 0; i < 4; i++) begin
        resp[i] <= '0;
      end
    end else begin
      lin.hdrStb <= 1'b0;
      irqSet <= '0;
      case (state)
        ST_IDLE: begin
          if (go) begin
            op <= lin_status_pkg::op_e'(wVal[2:1]);
            fetchSecond <= wVal[lin_status_pkg::CTRL_SECOND];
            state <= (wVal[2:1] == lin_status_pkg::OP_POS_DIRECT)
              ? ST_READ : ST_PREP;
          end
        end
        ST_PREP: begin
          lin.hdrStb <= 1'b1;
          if (op == lin_status_pkg::OP_FULL_DIAG) begin
            lin.pid <= lin_status_pkg::PID_DIAG_REQ;
            lin.masterLen <= lin_status_pkg::LEN_DIAG;
            lin.masterData <= {lin_status_pkg::APP_REQUEST_CODE,
                               cmdField, addrField, {5{8'hFF}}};
          end else begin
            lin.pid <= pidSel;
            lin.masterLen <= lin_status_pkg::LEN_SHORT;
            lin.masterData <= {cmdField, addrField, 48'h0};
          end
          state <= ST_PWAIT;
        end
        ST_PWAIT: begin
          if (lin.respStb) begin
            state <= ST_READ;
          end
        end
        ST_READ, ST_READ2: begin
          lin.hdrStb <= 1'b1;
          lin.masterLen <= lin_status_pkg::LEN_HEADER;
          lin.masterData <= '0;
          lin.pid <= (op == lin_status_pkg::OP_POS_DIRECT)
            ? pidSel : lin_status_pkg::PID_DIAG_RESP;
          state <= (state == ST_READ) ? ST_RWAIT : ST_R2WAIT;
        end
        ST_RWAIT: begin
          if (lin.respStb) begin
            resp[0] <= lin.respData[63:32];
            resp[1] <= lin.respData[31:0];
            if (!lin.respValid) begin
              irqSet[lin_status_pkg::IRQ_NO_RESP] <= 1'b1;
              state <= ST_IDLE;
            end else if (op[1] && fetchSecond) begin
              state <= ST_READ2;
            end else begin
              irqSet[lin_status_pkg::IRQ_DONE] <= 1'b1;
              state <= ST_IDLE;
            end
          end
        end
        default: begin
          if (lin.respStb) begin
            resp[2] <= lin.respData[63:32];
            resp[3] <= lin.respData[31:0];
            irqSet[lin.respValid ? lin_status_pkg::IRQ_DONE
                                 : lin_status_pkg::IRQ_NO_RESP] <= 1'b1;
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqStat <= '0;
      irq <= 1'b0;
    end else begin
      irqStat <= (irqStat & ~irqClr) | irqSet;
      irq <= |(irqStat & irqEn);
    end
  end
endmodule : lin_status_master

//--- tb/lin_status_properties.sv
// Link-side assertions watching both ends of the status link
`timescale 1ns/1ps
module lin_status_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hdrStb,
  input wire logic [7:0] pid,
  input wire logic [3:0] masterLen,
  input wire logic [63:0] masterData,
  input wire logic respStb,
  input wire logic respValid,
  input wire logic [3:0] respLen,
  input wire logic [63:0] respData
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  resp_follows_a: assert property (hdrStb |=> respStb)
    else $error("answer slot missing");
  resp_cause_a: assert property (respStb |-> $past(hdrStb))
    else $error("stray answer slot");
  diag_len_a: assert property (hdrStb
    && pid == lin_status_pkg::PID_DIAG_RESP
    |=> !respValid || respLen == lin_status_pkg::LEN_DIAG)
    else $error("diag answer not 8 bytes");
  silent_a: assert property (respStb && !respValid
    |-> respLen == 4'h0 && respData == '0)
    else $error("silent slot carries data");
  short_prep_a: assert property (hdrStb
    && masterLen == lin_status_pkg::LEN_SHORT |-> !pid[5] && masterData[63]
    && masterData[55] && masterData[47:0] == '0)
    else $error("bad short preparing frame");
  parity_a: assert property (hdrStb
    |-> pid[6] == ^{pid[4], pid[2:0]} && pid[7] == !(^{pid[5:3], pid[1]}))
    else $error("bad parity");
  diag_prep_a: assert property (hdrStb
    && masterLen == lin_status_pkg::LEN_DIAG
    |-> pid == lin_status_pkg::PID_DIAG_REQ
    && masterData[63:56] == lin_status_pkg::APP_REQUEST_CODE
    && masterData[39:0] == '1)
    else $error("bad diag preparing frame");
  read_hdr_a: assert property (hdrStb
    && pid == lin_status_pkg::PID_DIAG_RESP
    |-> masterLen == lin_status_pkg::LEN_HEADER)
    else $error("read frame has data");
  short_c: cover property (hdrStb && masterLen == lin_status_pkg::LEN_SHORT);
  diag_c: cover property (hdrStb && masterLen == lin_status_pkg::LEN_DIAG);
  direct_c: cover property (respValid && respLen == lin_status_pkg::LEN_FOUR);
endmodule : lin_status_properties

//--- tb/tb.sv
// Self-checking bench joining both ends of the status link
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0, rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [6:0] nodeAddr = 7'h15;
  logic [5:0] posId = 6'h25, prepId = 6'h1A;
  logic endSwitchState = 1'b1, rampProfile = 1'b1, shaftDir = 1'b0;
  logic [15:0] currentStepCount = 16'hABCF, targetPos = 16'h1234;
  logic [1:0] microstepResolution = 2'h2, tempInfo = 2'h1;
  logic [3:0] runCurrent = 4'hA, holdCurrent = 4'h3, speedMax = 4'hC;
  logic [3:0] speedMin = 4'h2, accel = 4'h6, busErrors = 4'h9;
  logic [3:0] absoluteThreshold = 4'h7, deltaThreshold = 4'h4;
  logic [2:0] motionState = 3'h5;
  logic [10:0] secondPos = 11'h5A6;
  logic [8:0] stallConfig = 9'h1A5;
  logic [12:0] faultSet = 13'h0, latchedFlags;
  int n_fail = 0, cmp_count = 0;
  logic [31:0] d;
  logic [1:0] r;
  lin_frame_if lin ();
  lin_status_master i_lin_status_master (.clk, .rst_n, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .irq,
    .lin(lin));
  lin_status_slave i_lin_status_slave (.clk, .rst_n, .lin(lin), .nodeAddr,
    .posId, .prepId, .endSwitchState, .currentStepCount, .microstepResolution,
    .runCurrent, .holdCurrent, .speedMax, .speedMin, .rampProfile, .shaftDir,
    .accel, .tempInfo, .motionState, .busErrors, .absoluteThreshold,
    .deltaThreshold, .targetPos, .secondPos, .stallConfig, .faultSet,
    .latchedFlags);
  lin_status_properties i_lin_status_properties (.clk, .rst_n,
    .hdrStb(lin.hdrStb), .pid(lin.pid), .masterLen(lin.masterLen),
    .masterData(lin.masterData), .respStb(lin.respStb),
    .respValid(lin.respValid), .respLen(lin.respLen),
    .respData(lin.respData));
  always #12.5 clk = ~clk;
  task automatic chk(input string nm, input logic [63:0] s, e);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    bit aw = 0, w = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk);
      if (awready) begin
        aw = 1;
        awvalid <= 1'b0;
      end
      if (wready) begin
        w = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  // Poll busy up to 40 reads; a hang fails the busy check
  task automatic run(input lin_status_pkg::op_e op, input logic sec);
    wr(lin_status_pkg::REG_CTRL, {28'h0, sec, op, 1'b1}, r);
    repeat (40) begin
      rd(lin_status_pkg::REG_STAT, d, r);
      if (d[0] === 1'b0) break;
    end
    chk("busy", d[0], 1'b0);
  endtask : run
  task automatic pulse_faults;
    faultSet <= 13'h1FFF;
    @(posedge clk);
    faultSet <= 13'h0;
  endtask : pulse_faults
  task automatic t_reset;
    chk("reset flags", latchedFlags, lin_status_pkg::FLAGS_RESET);
    wr(lin_status_pkg::REG_CFG, {11'h0, prepId[4:0], 2'h0, posId, 1'b0,
       nodeAddr}, r);
    chk("cfg resp", r, lin_status_pkg::RESP_OKAY);
    $display("Done reset test");
  endtask : t_reset
  task automatic t_pos(input lin_status_pkg::op_e op);
    pulse_faults();
    run(op, 1'b0);
    chk("flags kept", latchedFlags, 13'h1FFF);
    rd(lin_status_pkg::REG_RESP0, d, r);
    chk("pos word", d, {endSwitchState, nodeAddr, currentStepCount[15:2],
        2'h0, 6'h3F, tempInfo});
    if (op == lin_status_pkg::OP_POS_SHORT) begin
      rd(lin_status_pkg::REG_RESP1, d, r);
      chk("pos fill", d, 32'hFFFFFFFF);
    end
    $display("Done position test");
  endtask : t_pos
  task automatic t_full(input lin_status_pkg::op_e op, input logic sec);
    pulse_faults();
    run(op, sec);
    chk("flags cleared", latchedFlags, 13'h0);
    rd(lin_status_pkg::REG_RESP0, d, r);
    chk("full1 a", d, {1'b1, nodeAddr, runCurrent, holdCurrent, speedMax,
        speedMin, rampProfile, microstepResolution, shaftDir, accel});
    rd(lin_status_pkg::REG_RESP1, d, r);
    chk("full1 b", d, {6'h3F, tempInfo, motionState, endSwitchState, 4'hF,
        4'hF, busErrors, absoluteThreshold, deltaThreshold});
    if (sec) begin
      rd(lin_status_pkg::REG_RESP2, d, r);
      chk("full2 a", d, {1'b1, nodeAddr, currentStepCount[15:2], 2'h0,
          targetPos[15:8]});
      rd(lin_status_pkg::REG_RESP3, d, r);
      chk("full2 b", d, {targetPos[7:0], secondPos[7:0], stallConfig[8:6],
          1'b1, stallConfig[5], secondPos[10:8], 3'h0,
          stallConfig[4:0]});
    end
    $display("Done full status test");
  endtask : t_full
  task automatic t_irq;
    wr(lin_status_pkg::REG_IRQ_EN, 32'h1, r);
    run(lin_status_pkg::OP_POS_DIRECT, 1'b0);
    rd(lin_status_pkg::REG_IRQ_STAT, d, r);
    chk("done bit", d[0], 1'b1);
    chk("irq on", irq, 1'b1);
    wr(lin_status_pkg::REG_IRQ_CLR, 32'h1, r);
    rd(lin_status_pkg::REG_IRQ_STAT, d, r);
    chk("done cleared", d[0], 1'b0);
    chk("irq off", irq, 1'b0);
    wr(lin_status_pkg::REG_IRQ_EN, 32'h0, r);
    run(lin_status_pkg::OP_POS_DIRECT, 1'b0);
    chk("irq masked", irq, 1'b0);
    wr(lin_status_pkg::REG_IRQ_STAT, 32'h1, r);
    chk("ro write", r, lin_status_pkg::RESP_SLVERR);
    rd(8'h40, d, r);
    chk("unmapped resp", r, lin_status_pkg::RESP_SLVERR);
    chk("unmapped data", d, 32'h0);
    $display("Done interrupt test");
  endtask : t_irq
  task automatic tally_and_finish;
    $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_pos(lin_status_pkg::OP_POS_DIRECT);
    // Second answer skipped; the next request must still work
    t_full(lin_status_pkg::OP_FULL_SHORT, 1'b0);
    t_pos(lin_status_pkg::OP_POS_SHORT);
    t_full(lin_status_pkg::OP_FULL_DIAG, 1'b1);
    t_irq();
    tally_and_finish();
  end
  // Run takes well under a thousand cycles; the watchdog fires after 20000
  initial begin
    #500000;
    n_fail++;
    tally_and_finish();
  end
endmodule : tb
